// ---- src/ssv_pkg.sv ----
// Purpose: Shared constants and types for the shadow set and vector spacing control block.
// Assumes: Registers are reached over the core's coprocessor-0 move port (number, select).
// Notes: Field positions and reset values are named once here.
package ssv_pkg;
    // Coprocessor-0 addresses (register number, select).
    localparam logic [4:0] SSV_IRQ_CTL_NUM = 5'h0c;
    localparam logic [2:0] SSV_IRQ_CTL_SEL = 3'h1;
    localparam logic [4:0] SSV_SET_CTL_NUM = 5'h0c;
    localparam logic [2:0] SSV_SET_CTL_SEL = 3'h2;
    // Vector spacing field of interrupt_control.
    localparam int SSV_SPC_LSB = 5;
    localparam int SSV_SPC_MSB = 9;
    localparam logic [4:0] SSV_SPC_RESET = 5'h00;
    // Highest shadow set field of shadow_set_control.
    localparam int SSV_TOP_SET_LSB = 26;
    localparam int SSV_TOP_SET_MSB = 29;
    // Spacing codes and their byte distances.
    localparam logic [4:0] SSV_SPC_0 = 5'h00;
    localparam logic [4:0] SSV_SPC_32 = 5'h01;
    localparam logic [4:0] SSV_SPC_64 = 5'h02;
    localparam logic [4:0] SSV_SPC_128 = 5'h04;
    localparam logic [4:0] SSV_SPC_256 = 5'h08;
    localparam logic [4:0] SSV_SPC_512 = 5'h10;
    localparam logic [9:0] SSV_SP_0 = 10'h000;
    localparam logic [9:0] SSV_SP_32 = 10'h020;
    localparam logic [9:0] SSV_SP_64 = 10'h040;
    localparam logic [9:0] SSV_SP_128 = 10'h080;
    localparam logic [9:0] SSV_SP_256 = 10'h100;
    localparam logic [9:0] SSV_SP_512 = 10'h200;

    // Register access request from the core pipeline.
    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] num;
        logic [2:0] sel;
        logic [31:0] wdata;
    } ssv_req_t;
endpackage

// ---- src/ssv_ctl.sv ----
// Purpose: Vector spacing field and the head of the shadow set control register.
// Assumes: Single core clock; requests come from logic on the same clock.
// Notes: Reads return data one cycle after the request.
//
// Summary of operation
// - With vectored interrupts available, bits 9..5 of interrupt_control are a R/W spacing reset to 0.
// - Spacing codes 0,1,2,4,8,16 give entry spacing of 0,32,64,128,256,512 bytes.
// - shadow_set_control is reached as coprocessor-0 register 12 select 2.
// - shadow_set_control exists only in release 2 or later implementations.
// - Bits 31..30 of shadow_set_control read as zero and software writes them as zero.
// - Bits 29..26 of shadow_set_control report the fixed highest shadow set, read only.
// - That field reads 0 for one set, 1 for two sets and 3 for four sets.
// - A highest set value of 7 means eight sets; 2, 4-6 and 8-15 are reserved.
`timescale 1ns/10ps
module ssv_ctl
    import ssv_pkg::*;
#(
    parameter int ARCH_RELEASE = 2,
    parameter int NUM_SHADOW_SETS = 1
)
(
    input wire logic ref_clk_i, // Core clock, 250 MHz.
    input wire logic sys_rst_i, // Synchronous reset, active high.
    input wire logic clk_en_i, // Freezes all state while low, unless sys_rst_i is high.
    input wire logic vec_irq_cap_i, // vectored_irq_supported capability bit.
    input wire logic ext_irq_cap_i, // external_irq_ctrl_supported capability bit.
    input wire ssv_req_t req_i, // Register read or write request.
    output logic [31:0] rdata_o, // Read data, valid with rvalid_o.
    output logic rvalid_o, // One-cycle read answer strobe.
    output logic [9:0] vec_spacing_o // Byte distance between vector entries.
);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration check: only 1, 2, 4 or 8 sets have a legal encoding.
    // A count of 3 or 5 would need one of the reserved field encodings,
    // so such a build is refused rather than reporting a misleading value.
    initial
    begin
        if (!(NUM_SHADOW_SETS == 1 || NUM_SHADOW_SETS == 2 || NUM_SHADOW_SETS == 4
              || NUM_SHADOW_SETS == 8) || ARCH_RELEASE < 1)
        begin
            $error("ssv_ctl: unsupported shadow set count or release");
        end
    end

    // Highest shadow set number is fixed at build time.
    localparam logic [3:0] TOP_SET_VALUE = 4'(NUM_SHADOW_SETS - 1);
    // Older releases have no shadow set control register at all.
    localparam bit HAS_SET_CTL = (ARCH_RELEASE >= 2);

    ////////////////////////////////////////////////////////////////////////////
    // Maps a spacing code to bytes; unlisted codes yield zero.
    // Giving zero for unlisted codes keeps the entry address generator
    // from ever seeing a stride that no software is allowed to ask for.
    function automatic logic [9:0] spacing_of(input logic [4:0] code);
        logic [9:0] sp;
        sp = SSV_SP_0;
        case (code)
            SSV_SPC_32: sp = SSV_SP_32;
            SSV_SPC_64: sp = SSV_SP_64;
            SSV_SPC_128: sp = SSV_SP_128;
            SSV_SPC_256: sp = SSV_SP_256;
            SSV_SPC_512: sp = SSV_SP_512;
            default: sp = SSV_SP_0;
        endcase
        return sp;
    endfunction

    // True when a request addresses the given register number and select.
    function automatic logic hit(input ssv_req_t r, input logic [4:0] n, input logic [2:0] s);
        return (r.num == n) && (r.sel == s);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic [4:0] spc_code;
    logic [4:0] next_spc_code;
    logic [31:0] next_rdata;
    logic next_rvalid;
    logic [9:0] next_spacing;
    logic vec_impl;
    logic irq_ctl_wr;
    logic irq_ctl_rd;
    logic set_ctl_rd;

    // Field only exists when one of the capability bits is set.
    assign vec_impl = vec_irq_cap_i | ext_irq_cap_i;

    // Decoded requests; each is used by the next-state logic and the checks.
    assign irq_ctl_wr = req_i.wr && hit(req_i, SSV_IRQ_CTL_NUM, SSV_IRQ_CTL_SEL);
    assign irq_ctl_rd = req_i.rd && hit(req_i, SSV_IRQ_CTL_NUM, SSV_IRQ_CTL_SEL);
    assign set_ctl_rd = req_i.rd && hit(req_i, SSV_SET_CTL_NUM, SSV_SET_CTL_SEL);

    // Next state of the spacing field and of the read port.
    // A read in the same cycle as a write returns the old value, since the
    // read data is built from the stored code and not from next_spc_code.
    always_comb
    begin
        next_spc_code = spc_code;
        next_rdata = 32'h0000_0000;
        next_rvalid = 1'b0;
        if (irq_ctl_wr && vec_impl)
        begin
            next_spc_code = req_i.wdata[SSV_SPC_MSB:SSV_SPC_LSB];
        end
        if (req_i.rd)
        begin
            next_rvalid = 1'b1;
            if (irq_ctl_rd)
            begin
                // Low bits stay zero by construction.
                next_rdata[SSV_SPC_MSB:SSV_SPC_LSB] = vec_impl ? spc_code : 5'h00;
            end
            else if (HAS_SET_CTL && set_ctl_rd)
            begin
                // Top two bits stay zero; writes leave this field alone.
                next_rdata[SSV_TOP_SET_MSB:SSV_TOP_SET_LSB] = TOP_SET_VALUE;
            end
        end
        // Spacing follows the code that will be stored, so it is current
        // in the same cycle as the register itself.
        next_spacing = vec_impl ? spacing_of(next_spc_code) : SSV_SP_0;
    end

    // Registers; reset wins, otherwise a low clock enable freezes everything.
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            spc_code <= SSV_SPC_RESET;
            rdata_o <= 32'h0000_0000;
            rvalid_o <= 1'b0;
            vec_spacing_o <= SSV_SP_0;
        end
        else if (clk_en_i)
        begin
            spc_code <= next_spc_code;
            rdata_o <= next_rdata;
            rvalid_o <= next_rvalid;
            vec_spacing_o <= next_spacing;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    // A taken read of the shadow set control register.
    sequence s_set_ctl_read;
        clk_en_i && set_ctl_rd;
    endsequence

    // A taken write of the spacing field while the field exists.
    sequence s_spc_write;
        clk_en_i && irq_ctl_wr && vec_impl;
    endsequence

    // A taken read of interrupt_control with no write beside it.
    sequence s_spc_read;
        clk_en_i && irq_ctl_rd && !req_i.wr;
    endsequence

    chk_set_ctl_fixed: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        s_set_ctl_read |=> rdata_o == (HAS_SET_CTL ? {2'b00, TOP_SET_VALUE, 26'h0} : 32'h0))
        else $error("shadow set control read value wrong");
    chk_set_top_zero: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        rvalid_o |-> rdata_o[31:30] == 2'b00)
        else $error("reserved top bits not zero");
    chk_ic_low_zero: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        rvalid_o |-> rdata_o[4:0] == 5'h00)
        else $error("reserved low bits not zero");
    chk_spc_write: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        s_spc_write ##1 s_spc_read |=> rdata_o[9:5] == $past(req_i.wdata[9:5], 2))
        else $error("spacing field did not store write");
    chk_spc_bytes: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        clk_en_i && vec_impl && next_spc_code == SSV_SPC_512 |=> vec_spacing_o == SSV_SP_512)
        else $error("spacing output wrong");
    chk_read_answer: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        clk_en_i && req_i.rd |=> rvalid_o)
        else $error("read not answered next cycle");
    // Without either capability the spacing output must fall to zero.
    chk_no_cap_zero: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        clk_en_i && !vec_impl |=> vec_spacing_o == SSV_SP_0)
        else $error("spacing present without capability");
    // Reset clears the read port and the spacing in one edge.
    chk_reset_clear: assert property (@(posedge ref_clk_i)
        sys_rst_i |=> !rvalid_o && vec_spacing_o == SSV_SP_0)
        else $error("reset did not clear outputs");
    // A low clock enable keeps the stored code unchanged.
    chk_freeze_hold: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        !clk_en_i |=> spc_code == $past(spc_code))
        else $error("state changed while frozen");
endmodule

// ---- testbench/ssv_ctl_tb.sv ----
// Purpose: Self-checking bench for the spacing field and shadow set control head.
// Assumes: Inputs change on the falling edge; reads answer one cycle after they are taken.
// Notes: A second instance models a release 1 core without shadow_set_control.
`timescale 1ns/10ps
module ssv_ctl_tb;
    import ssv_pkg::*;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic clk_en_i = 1'b1;
    logic vec_irq_cap_i = 1'b1;
    logic ext_irq_cap_i = 1'b0;
    ssv_req_t req_i = '0;
    logic [31:0] rdata_o;
    logic [31:0] rdata_r1;
    logic rvalid_o;
    logic [9:0] vec_spacing_o;
    logic [31:0] cap_rdata = '0;
    logic [31:0] cap_r1 = '0;
    logic cap_valid = 1'b0;
    int n_fail = 0;
    int tests_run = 0;
    logic [4:0] codes [6] = '{SSV_SPC_0, SSV_SPC_32, SSV_SPC_64, SSV_SPC_128, SSV_SPC_256,
        SSV_SPC_512};
    logic [9:0] bytes [6] = '{SSV_SP_0, SSV_SP_32, SSV_SP_64, SSV_SP_128, SSV_SP_256, SSV_SP_512};
    ////////////////////////////////////////////////////////////////////////////////
    // Four shadow sets, so the highest set field should read 3.
    ssv_ctl #(.ARCH_RELEASE(2), .NUM_SHADOW_SETS(4)) ssv_ctl_inst (.ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .vec_irq_cap_i(vec_irq_cap_i),
        .ext_irq_cap_i(ext_irq_cap_i), .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
        .vec_spacing_o(vec_spacing_o));
    ssv_ctl #(.ARCH_RELEASE(1), .NUM_SHADOW_SETS(4)) ssv_ctl_r1_inst (.ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .vec_irq_cap_i(vec_irq_cap_i),
        .ext_irq_cap_i(ext_irq_cap_i), .req_i(req_i), .rdata_o(rdata_r1), .rvalid_o(),
        .vec_spacing_o());
    ////////////////////////////////////////////////////////////////////////////////
    // Free-running 250 MHz clock.
    initial
    begin
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk10(input logic [9:0] got, input logic [9:0] exp);
        chk32({22'h0, got}, {22'h0, exp});
    endtask
    // One request held for a single edge; the answer stands for one cycle only,
    // so it is captured at the next falling edge, before the idle edge clears it.
    task automatic access(input logic r, input logic w, input logic [2:0] s, input logic [31:0] d);
        req_i = '{rd: r, wr: w, num: 5'h0c, sel: s, wdata: d};
        @(negedge ref_clk_i);
        cap_rdata = rdata_o;
        cap_valid = rvalid_o;
        cap_r1 = rdata_r1;
        req_i = '0;
        @(negedge ref_clk_i);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog sized well above the roughly 50 cycles the sequence needs.
    initial
    begin
        #4000;
        n_fail++;
        report_and_stop();
    end
    // Main sequence: spacing table first, then the awkward cases.
    initial
    begin
        repeat (6) @(negedge ref_clk_i);
        sys_rst_i = 1'b0;
        chk10(vec_spacing_o, SSV_SP_0);
        for (int i = 0; i < 6; i++)
        begin
            // Only listed codes are written, with the reserved low bits zero.
            access(1'b0, 1'b1, SSV_IRQ_CTL_SEL, {22'h0, codes[i], 5'h00});
            chk10(vec_spacing_o, bytes[i]);
            access(1'b1, 1'b0, SSV_IRQ_CTL_SEL, 32'h0);
            chk32({31'h0, cap_valid}, 32'h1);
            chk32(cap_rdata, {22'h0, codes[i], 5'h00});
            $display("spacing row %0d done", i);
        end
        access(1'b1, 1'b0, SSV_SET_CTL_SEL, 32'h0);
        chk32(cap_rdata, 32'h0c000000);
        chk32(cap_r1, 32'h0);
        // A write of 15 to the read-only highest set field is ignored; top bits written as zero.
        access(1'b0, 1'b1, SSV_SET_CTL_SEL, 32'h3c000000);
        access(1'b1, 1'b0, SSV_SET_CTL_SEL, 32'h0);
        chk32(cap_rdata, 32'h0c000000);
        access(1'b1, 1'b0, 3'h3, 32'h0);
        chk32(cap_rdata, 32'h0);
        $display("shadow set reads done");
        // Without either capability the field is absent; the second bit alone restores it.
        vec_irq_cap_i = 1'b0;
        access(1'b1, 1'b1, SSV_IRQ_CTL_SEL, {22'h0, SSV_SPC_64, 5'h00});
        chk32(cap_rdata, 32'h0);
        chk10(vec_spacing_o, SSV_SP_0);
        ext_irq_cap_i = 1'b1;
        access(1'b0, 1'b1, SSV_IRQ_CTL_SEL, {22'h0, SSV_SPC_128, 5'h00});
        chk10(vec_spacing_o, SSV_SP_128);
        clk_en_i = 1'b0;
        access(1'b0, 1'b1, SSV_IRQ_CTL_SEL, {22'h0, SSV_SPC_256, 5'h00});
        clk_en_i = 1'b1;
        chk10(vec_spacing_o, SSV_SP_128);
        access(1'b1, 1'b1, SSV_IRQ_CTL_SEL, {22'h0, SSV_SPC_512, 5'h00});
        chk32(cap_rdata, {22'h0, SSV_SPC_128, 5'h00});
        chk10(vec_spacing_o, SSV_SP_512);
        // Write then read on the very next edge: the read sees the new code.
        req_i = '{rd: 1'b0, wr: 1'b1, num: SSV_IRQ_CTL_NUM, sel: SSV_IRQ_CTL_SEL,
            wdata: {22'h0, SSV_SPC_64, 5'h00}};
        @(negedge ref_clk_i);
        req_i = '{rd: 1'b1, wr: 1'b0, num: SSV_IRQ_CTL_NUM, sel: SSV_IRQ_CTL_SEL, wdata: 32'h0};
        @(negedge ref_clk_i);
        cap_rdata = rdata_o;
        req_i = '0;
        @(negedge ref_clk_i);
        chk32(cap_rdata, {22'h0, SSV_SPC_64, 5'h00});
        chk10(vec_spacing_o, SSV_SP_64);
        $display("capability and ordering cases done");
        sys_rst_i = 1'b1;
        @(negedge ref_clk_i);
        sys_rst_i = 1'b0;
        chk10(vec_spacing_o, SSV_SP_0);
        $display("mid-run reset done");
        report_and_stop();
    end
endmodule
